// ==== bench/ppg_timer_assertions.sv ====
// Purpose: Port-level checks for the pulse / warm-up timer
// Assumes: ce high around bus transfers and interrupts, period compare of 2 or more
// Notes:   Tracks upper control writes to know mode and run state
`timescale 1ns/1ns
module ppg_timer_checker (
    // Clock and reset
    input wire        clock,
    input wire        arst_n,
    input wire        ce,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Timer
    input wire        lowFreqTick,
    input wire        extIn,
    input wire        pulse_out_n,
    input wire        period_match_irq
);
    logic [7:0] upper_q;
    wire        wrUpper = pready && psel && penable && pwrite && paddr == 12'h004;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            upper_q <= 8'h00;
        else if (wrUpper)
            upper_q <= pwdata[7:0];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence

    // ==========
    // Bus answer
    a_ready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_map: assert property (pready |-> pslverr == (paddr > 12'h018))
        else $error("pslverr wrong");
    a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    // ==========
    // Timer
    a_pin_inverse: assert property (pready && !pwrite && paddr == 12'h018 |->
        prdata[16] != $past(pulse_out_n)) else $error("pin not inverse of flop");
    a_irq_pulse: assert property (period_match_irq |=> !period_match_irq)
        else $error("irq longer than one cycle");
    a_ppg_toggle: assert property (period_match_irq && upper_q[2:0] == 3'h7 |->
        pulse_out_n != $past(pulse_out_n)) else $error("no toggle at period");
    a_warm_hold: assert property (period_match_irq && upper_q[2:0] == 3'h5 |->
        $stable(pulse_out_n)) else $error("warm-up moved pin");
    a_idle_quiet: assert property (!upper_q[3] && !$past(upper_q[3]) |->
        !period_match_irq) else $error("irq while stopped");
    a_stop_hold: assert property (!upper_q[3] && !$past(upper_q[3]) &&
        $changed(pulse_out_n) |-> $past(wrUpper)) else $error("pin moved while stopped");
    a_flop_load: assert property (wrUpper && !upper_q[3] && !pwdata[3] |=>
        pulse_out_n == !$past(pwdata[7])) else $error("flop not loaded");
endmodule

bind ppg_warmup_timer ppg_timer_checker chk_i (.clock, .arst_n, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lowFreqTick, .extIn,
    .pulse_out_n, .period_match_irq);

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the pulse / warm-up timer
// Assumes: ce high except one freeze test; tick sources run free
// Notes:   Gaps are counted in clock cycles between period interrupts
`timescale 1ns/1ns
`include "ppg_timer_consts.vh"
module tb_top;
    logic        clock, arst_n, ce, psel, penable, pwrite, lowFreqTick, extIn, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [2:0]  lfCnt, extCnt;
    wire  [31:0] prdata;
    wire         pready, pslverr, pulse_out_n, period_match_irq;
    int          err_count, n_compared, gap, lowCnt;

    // Pin is read straight off the port; the shared port latch lies outside
    ppg_warmup_timer ppg_warmup_timer_i (.clock, .arst_n, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .lowFreqTick, .extIn,
        .pulse_out_n, .period_match_irq);

    always #5 clock = ~clock;
    // Slow tick every 5 cycles, pin falls every 8 cycles (levels held 4)
    always @(posedge clock) begin
        lfCnt <= (lfCnt == 3'h4) ? 3'h0 : lfCnt + 3'h1;
        lowFreqTick <= (lfCnt == 3'h4);
        extCnt <= extCnt + 3'h1;
        extIn <= ~extCnt[2];
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge clock);
            t++;
        end
        rd = prdata;
        er = pslverr;
        if (t == 20)
            err_count++;
        psel <= 0;
        penable <= 0;
    endtask

    // Low byte first, then high byte
    task automatic w16(logic [11:0] a, logic [15:0] v);
        apb(1, a, {24'h0, v[7:0]});
        apb(1, a + 12'h004, {24'h0, v[15:8]});
    endtask

    task automatic measure(output int g, output int lo);
        int t;
        t = 0;
        while (period_match_irq !== 1'b1 && t < 1000) begin
            @(posedge clock);
            t++;
        end
        g = 0;
        lo = 0;
        do begin
            @(posedge clock);
            g++;
            lo += (pulse_out_n === 1'b0);
        end while (period_match_irq !== 1'b1 && g < 1000);
        if (t == 1000 || g == 1000)
            err_count++;
    endtask

    task automatic t_reset;
        check("pin", pulse_out_n, 1);
        for (int a = 0; a < 28; a += 4) begin
            apb(0, 12'(a), 0);
            check("reset value", rd, 0);
        end
        apb(0, 12'h01C, 0);
        check("unmapped err", er, 1);
        apb(1, `ADDR_WIDTH_LOW, 32'hA5);
        apb(0, `ADDR_WIDTH_LOW, 0);
        check("readback", rd, 32'hA5);
        $display("t_reset done");
    endtask

    task automatic t_ppg;
        logic h;
        w16(`ADDR_WIDTH_LOW, 16'h0001);
        w16(`ADDR_PERIOD_LOW, 16'h0004);
        apb(1, `ADDR_LOWER_CTRL, 32'h60);
        for (int f = 0; f < 2; f++) begin
            apb(1, `ADDR_UPPER_CTRL, 32'h07);
            apb(1, `ADDR_UPPER_CTRL, f ? 32'h87 : 32'h07);
            @(posedge clock);
            check("init pin", pulse_out_n, !f);
            apb(1, `ADDR_UPPER_CTRL, f ? 32'h8F : 32'h0F);
            measure(gap, lowCnt);
            check("ppg gap", gap, 4);
            check("ppg low", lowCnt, f ? 1 : 3);
        end
        apb(1, `ADDR_PERIOD_LOW, 32'h08);
        measure(gap, lowCnt);
        check("new period", gap, 8);
        apb(0, `ADDR_STATUS, 0);
        apb(1, `ADDR_UPPER_CTRL, 32'h87);
        @(posedge clock);
        h = pulse_out_n;
        repeat (20) @(posedge clock);
        check("hold pin", pulse_out_n, h);
        apb(0, `ADDR_STATUS, 0);
        check("status flop", rd[16], !h);
        apb(1, `ADDR_UPPER_CTRL, 32'h07);
        @(posedge clock);
        check("clear pin", pulse_out_n, 1);
        $display("t_ppg done");
    endtask

    task automatic t_src;
        int sel[5] = '{6, 5, 4, 7, 3};
        int mul[5] = '{1, 2, 5, 8, 8};
        w16(`ADDR_WIDTH_LOW, 16'h0002);
        w16(`ADDR_PERIOD_LOW, 16'h0004);
        foreach (sel[i]) begin
            apb(1, `ADDR_UPPER_CTRL, 32'h07);
            apb(1, `ADDR_LOWER_CTRL, 32'(sel[i] << 4));
            apb(1, `ADDR_UPPER_CTRL, 32'h0F);
            measure(gap, lowCnt);
            check("src gap", gap, 4 * mul[i]);
            check("src low", lowCnt, 2 * mul[i]);
        end
        $display("t_src done");
    endtask

    task automatic t_warm;
        logic [15:0] per[3] = '{16'h01FF, 16'h0200, 16'h0080};
        int          exp[3] = '{256, 512, 256};
        int          g;
        foreach (per[i]) begin
            apb(1, `ADDR_UPPER_CTRL, 32'h05);
            apb(1, `ADDR_LOWER_CTRL, 32'h60);
            w16(`ADDR_PERIOD_LOW, per[i]);
            apb(1, `ADDR_UPPER_CTRL, 32'h0D);
            measure(gap, lowCnt);
            check("warm gap", gap, exp[i]);
            check("warm pin", lowCnt, 0);
        end
        // Freeze just after a match, well clear of the next one
        ce <= 0;
        repeat (50) @(posedge clock);
        ce <= 1;
        g = 0;
        do begin
            @(posedge clock);
            g++;
        end while (period_match_irq !== 1'b1 && g < 1000);
        check("ce freeze", 50 + g, 306);
        apb(1, `ADDR_UPPER_CTRL, 32'h05);
        $display("t_warm done");
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        close_out;
    end

    initial begin
        clock = 0;
        arst_n = 0;
        ce = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        lowFreqTick = 0;
        extIn = 1;
        lfCnt = 0;
        extCnt = 0;
        repeat (2) @(posedge clock);
        arst_n <= 1;
        t_reset;
        t_ppg;
        t_src;
        t_warm;
        close_out;
    end
endmodule

// ==== hw/count_tick_gen.v ====
// Purpose: Count-enable tick for the 16-bit timer from the selected source
// Assumes: All inputs synchronous to clock
// Notes:   External pin counts on its falling edge
`timescale 1ns/1ns
`include "ppg_timer_consts.vh"

module count_tick_gen (
    // Clock and reset
    input  wire       clock,
    input  wire       arst_n,
    input  wire       ce,
    // Source selection
    input  wire [2:0] clkSel,
    input  wire       lowFreqTick,
    input  wire       extIn,
    // Tick out
    output reg        tick
);

    reg  [10:0] prescale_q;
    reg         extPrev_q;
    wire        extFall;

    // ==========================================================
    // Free-running prescaler
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prescale_q <= 11'h000;
            extPrev_q  <= 1'b1;
        end else if (ce) begin
            prescale_q <= prescale_q + 11'h001;
            extPrev_q  <= extIn;
        end
    end

    // relies on slow input
    // Edge detect needs each level to last over a sample, else pulses are lost
    assign extFall = extPrev_q & ~extIn;

    // ==========================================================
    // Source multiplexer
    always @* begin
        case (clkSel)
            `CLK_DIV2048: tick = &prescale_q[10:0];
            `CLK_DIV128:  tick = &prescale_q[6:0];
            `CLK_DIV32:   tick = &prescale_q[4:0];
            `CLK_DIV8:    tick = &prescale_q[2:0];
            `CLK_LOWFREQ: tick = lowFreqTick;
            `CLK_DIV2:    tick = prescale_q[0];
            `CLK_DIV1:    tick = 1'b1;
            `CLK_EXTPIN:  tick = extFall;
            default:      tick = 1'b0;
        endcase
    end

endmodule

// ==== hw/ppg_timer_consts.vh ====
// Purpose: Constants for the cascaded pulse generator / warm-up timer
// Assumes: 100 MHz clock, APB register access, byte addresses below
// Notes:   Included by every design file of the timer
//
// Functional notes
// - Two 8-bit counters form one 16-bit up-counter, internal or external clock.
// - Pulse mode: counter equals width register, flop toggles, counter keeps running.
// - Pulse mode: counter equals period register, flop toggles, counter clears, interrupt.
// - Flop starting level loads from control bit; reset clears flop to 0.
// - Pulse output pin is always the inverse of the flop.
// - No shadow buffering; new compare values act at once; avoid changing while running.
// - Stopping holds the pin; flop level changes only by a later write.
// - Upper control bit 3 clear stops counting; bit 7 clear clears flop when written while stopped.
// - Warm-up mode compares only upper 8 bits of the period register.
// - Warm-up mode: after start, period match raises interrupt and clears counter.
// - Usable warm-up period range is 0100H to FF00H.

`ifndef PPG_TIMER_CONSTS_VH
`define PPG_TIMER_CONSTS_VH

// ==========================================================
// Register byte addresses
`define ADDR_LOWER_CTRL     12'h000
`define ADDR_UPPER_CTRL     12'h004
`define ADDR_WIDTH_LOW      12'h008
`define ADDR_WIDTH_HIGH     12'h00C
`define ADDR_PERIOD_LOW     12'h010
`define ADDR_PERIOD_HIGH    12'h014
`define ADDR_STATUS         12'h018

// ==========================================================
// Field positions
`define UPPER_FLOP_BIT      7
`define UPPER_RUN_BIT       3
`define UPPER_MODE_MSB      2
`define LOWER_CLK_MSB       6
`define LOWER_CLK_LSB       4
`define STATUS_FLOP_BIT     16

// ==========================================================
// Modes in upper control bits 2:0
`define MODE_PPG            3'h7
`define MODE_WARMUP         3'h5

// ==========================================================
// Clock select codes
`define CLK_DIV2048         3'h0
`define CLK_DIV128          3'h1
`define CLK_DIV32           3'h2
`define CLK_DIV8            3'h3
`define CLK_LOWFREQ         3'h4
`define CLK_DIV2            3'h5
`define CLK_DIV1            3'h6
`define CLK_EXTPIN          3'h7

// ==========================================================
// Reset values and limits
`define RST_CTRL            8'h00
`define RST_COMPARE         8'h00
`define WARM_HIGH_MIN       8'h01
`define WARM_HIGH_MAX       8'hFF

`endif

// ==== hw/ppg_warmup_timer.v ====
// Purpose: Cascaded 16-bit pulse generator and clock warm-up timer
// Assumes: APB slave, one wait state per transfer, 8-bit registers except the status read (flop at bit 16, 16-bit count)
// Notes:   Compare registers have no shadow copies
`timescale 1ns/1ns
`include "ppg_timer_consts.vh"

module ppg_warmup_timer (
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Count sources
    input  wire        lowFreqTick,
    input  wire        extIn,
    // Outputs
    output reg         pulse_out_n,
    output reg         period_match_irq
);

    // ==========================================================
    // Register state
    reg  [7:0]  lowerCtrl_q;
    reg  [7:0]  upperCtrl_q;
    reg  [7:0]  widthLow_q;
    reg  [7:0]  widthHigh_q;
    reg  [7:0]  periodLow_q;
    reg  [7:0]  periodHigh_q;
    reg  [15:0] count_q;
    reg  [15:0] count_d;
    reg         flop_q;
    reg         flop_d;
    reg         irq_d;

    wire        tick;
    wire        busAccess;
    wire        wrEn;
    wire        running;
    wire        modePpg;
    wire        modeWarm;
    wire        startRise;
    wire        ctrlWrite;
    wire [7:0]  wrByte;
    wire [15:0] widthVal;
    wire [15:0] periodVal;
    wire [15:0] countInc;
    reg  [7:0]  warmHigh;
    reg  [31:0] readVal;
    reg         addrOk;

    assign widthVal  = {widthHigh_q, widthLow_q};
    assign periodVal = {periodHigh_q, periodLow_q};
    assign countInc  = count_q + 16'h0001;
    assign wrByte    = pwdata[7:0];
    assign modePpg   = upperCtrl_q[`UPPER_MODE_MSB:0] == `MODE_PPG;
    assign modeWarm  = upperCtrl_q[`UPPER_MODE_MSB:0] == `MODE_WARMUP;

    assign running   = upperCtrl_q[`UPPER_RUN_BIT] & (modePpg | modeWarm);

    // ==========================================================
    // APB handshake: the access phase sees one wait state
    assign busAccess = psel & penable & pready;
    assign wrEn      = busAccess & pwrite;
    assign ctrlWrite = wrEn & (paddr == `ADDR_UPPER_CTRL);

    assign startRise = ctrlWrite & wrByte[`UPPER_RUN_BIT] & ~upperCtrl_q[`UPPER_RUN_BIT];

    always @* begin
        addrOk  = 1'b1;
        readVal = 32'h0000_0000;
        case (paddr)
            `ADDR_LOWER_CTRL:  readVal[7:0] = lowerCtrl_q;
            `ADDR_UPPER_CTRL:  readVal[7:0] = upperCtrl_q;
            `ADDR_WIDTH_LOW:   readVal[7:0] = widthLow_q;
            `ADDR_WIDTH_HIGH:  readVal[7:0] = widthHigh_q;
            `ADDR_PERIOD_LOW:  readVal[7:0] = periodLow_q;
            `ADDR_PERIOD_HIGH: readVal[7:0] = periodHigh_q;
            `ADDR_STATUS:      readVal = {15'h0000, flop_q, count_q};
            default:           addrOk = 1'b0;
        endcase
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (psel & penable & ~pready) begin
                pready  <= 1'b1;
                pslverr <= ~addrOk;
                prdata  <= pwrite ? 32'h0000_0000 : readVal;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register writes
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lowerCtrl_q  <= `RST_CTRL;
            upperCtrl_q  <= `RST_CTRL;
            widthLow_q   <= `RST_COMPARE;
            widthHigh_q  <= `RST_COMPARE;
            periodLow_q  <= `RST_COMPARE;
            periodHigh_q <= `RST_COMPARE;
        end else if (ce && wrEn) begin
            case (paddr)
                `ADDR_LOWER_CTRL:  lowerCtrl_q  <= wrByte;
                `ADDR_UPPER_CTRL:  upperCtrl_q  <= wrByte;
                `ADDR_WIDTH_LOW:   widthLow_q   <= wrByte;
                `ADDR_WIDTH_HIGH:  widthHigh_q  <= wrByte;
                `ADDR_PERIOD_LOW:  periodLow_q  <= wrByte;
                `ADDR_PERIOD_HIGH: periodHigh_q <= wrByte;
                default:           lowerCtrl_q  <= lowerCtrl_q;
            endcase
        end
    end

    // ==========================================================
    // Count source
    // selected clock source
    count_tick_gen u_tick (
        .clock       (clock),
        .arst_n      (arst_n),
        .ce          (ce),
        .clkSel      (lowerCtrl_q[`LOWER_CLK_MSB:`LOWER_CLK_LSB]),
        .lowFreqTick (lowFreqTick),
        .extIn       (extIn),
        .tick        (tick)
    );

    // ==========================================================
    // Warm-up compare byte
    always @* begin
        // clamp warm-up range
        // A zero high byte would match instantly; the floor keeps at least 256 ticks
        if (periodHigh_q < `WARM_HIGH_MIN) begin
            warmHigh = `WARM_HIGH_MIN;
        end else begin
            warmHigh = periodHigh_q;
        end
    end

    // ==========================================================
    // Counter and output flop next state
    always @* begin
        count_d = count_q;
        flop_d  = flop_q;
        irq_d   = 1'b0;
        if (startRise) begin
            count_d = 16'h0000;
        end else if (running && tick) begin
            if (modePpg) begin
                if (countInc == periodVal) begin
                    flop_d  = ~flop_q;
                    count_d = 16'h0000;
                    irq_d   = 1'b1;
                end else begin
                    count_d = countInc;
                    if (countInc == widthVal) begin
                        flop_d = ~flop_q;
                    end
                end
            end else begin
                if (countInc[15:8] == warmHigh) begin
                    count_d = 16'h0000;
                    irq_d   = 1'b1;
                end else begin
                    count_d = countInc;
                end
            end
        end
        // load only when stopped
        // A write that stops the timer keeps the pin where it was
        if (ctrlWrite && !upperCtrl_q[`UPPER_RUN_BIT]) begin
            flop_d = wrByte[`UPPER_FLOP_BIT];
        end
    end

    // ==========================================================
    // State and output flops
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q          <= 16'h0000;
            flop_q           <= 1'b0;
            pulse_out_n      <= 1'b1;
            period_match_irq <= 1'b0;
        end else if (ce) begin
            count_q          <= count_d;
            flop_q           <= flop_d;
            pulse_out_n      <= ~flop_d;
            period_match_irq <= irq_d;
        end
    end

endmodule
